// >>> pcd_pkg.sv
// Pulse command decoder: register map, field layout, modes and timing
// Assumes a 125 MHz register clock and a 32-bit APB slave port
// Behaviour
// - Position commands come as step/direction, up/down pulses, or quadrature pair.
// - Step/direction mode: every step pulse advances commanded position one increment.
// - Step/direction mode: direction input level selects forward or backward steps.
// - Up/down mode: one input moves clockwise, the other counter-clockwise.
// - Quadrature mode: phase order gives direction, edge rate gives speed.
// - Counted pulses are scaled by a programmable pulses-to-revolution ratio.
// - Velocity/torque commands come as duty plus direction, or centred duty.
// - Duty/direction mode: measured duty cycle sets command magnitude.
// - Duty/direction mode: direction input level sets command polarity.
// - Centred mode: one input gives both magnitude and sign.
// - Centred mode: exactly half duty gives zero command.
// - Centred mode: duty toward always-high drives command to positive full scale.
// - Centred mode: always-low input gives negative full scale.
package pcd_pkg;

  localparam logic [7:0]  PCD_OFS_CTRL   = 8'h00;
  localparam logic [7:0]  PCD_OFS_NUM    = 8'h04;
  localparam logic [7:0]  PCD_OFS_DEN    = 8'h08;
  localparam logic [7:0]  PCD_OFS_POS    = 8'h0C;
  localparam logic [7:0]  PCD_OFS_CNT    = 8'h10;
  localparam logic [7:0]  PCD_OFS_DUTY   = 8'h14;
  localparam logic [7:0]  PCD_OFS_PERIOD = 8'h18;

  localparam int unsigned PCD_CTRL_FMT   = 0;
  localparam int unsigned PCD_CTRL_VT    = 2;
  localparam int unsigned PCD_CTRL_CTR   = 3;
  localparam int unsigned PCD_CTRL_EN    = 4;
  localparam int unsigned PCD_CTRL_W     = 5;

  localparam logic [4:0]  PCD_CTRL_RST   = 5'h00;
  localparam logic [15:0] PCD_NUM_RST    = 16'h0001;
  localparam logic [15:0] PCD_DEN_RST    = 16'h0001;

  localparam logic [15:0] PCD_FS         = 16'h4000;
  localparam logic [15:0] PCD_HALF       = 16'h2000;
  localparam int unsigned PCD_FS_SHIFT   = 14;
  localparam int unsigned PCD_CNT_W      = 20;

  localparam int unsigned PCD_CLK_NS     = 8;
  localparam int unsigned PCD_STUCK_NS   = 1000000;
  localparam logic [19:0] PCD_STUCK_CYC  = 20'(PCD_STUCK_NS / PCD_CLK_NS);

  typedef enum logic [5:0] {
    PCD_M_OFF    = 6'b000001,
    PCD_M_STEP   = 6'b000010,
    PCD_M_UPDN   = 6'b000100,
    PCD_M_QUAD   = 6'b001000,
    PCD_M_PWMDIR = 6'b010000,
    PCD_M_CENTRE = 6'b100000
  } pcd_mode_t;

endpackage

// >>> pcd_sync.sv
// Three-stage input synchroniser with agreement filter and edge pulses
// Assumes an asynchronous pin and the drive clock pclk
`timescale 1ns/1ps
module pcd_sync import pcd_pkg::*; (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pin and result
  input  wire logic pin,
  output logic      lvl_ff,
  output logic      rise_ff,
  output logic      fall_ff
);
  logic s1_ff, s2_ff, s3_ff;
  logic nxt_lvl;

  always_comb begin
    nxt_lvl = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff   <= 1'b0;
      s2_ff   <= 1'b0;
      s3_ff   <= 1'b0;
      lvl_ff  <= 1'b0;
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end else begin
      s1_ff   <= pin;
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      lvl_ff  <= nxt_lvl;
      rise_ff <= nxt_lvl & ~lvl_ff;
      fall_ff <= ~nxt_lvl & lvl_ff;
    end
  end

  edge_once_a: assert property (@(posedge pclk) disable iff (!presetn)
    rise_ff |=> !rise_ff) else $error("rise pulse longer than one cycle");

endmodule // pcd_sync

// >>> pcd_duty.sv
// Duty-cycle meter: high time over period, measured from rise to rise
// Assumes synchronised level and rise pulse from pcd_sync
`timescale 1ns/1ps
module pcd_duty import pcd_pkg::*; #(
  parameter logic [19:0] STUCK_CYC = PCD_STUCK_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Input signal
  input  wire logic        sig_lvl,
  input  wire logic        sig_rise,
  // Measurement
  output logic [15:0]      duty_ff,
  output logic [19:0]      period_ff,
  output logic             meas_ff
);
  logic [19:0] hi_ff, per_ff, nxt_hi, nxt_per, nxt_period;
  logic [15:0] nxt_duty;
  logic        seen_ff, nxt_seen, nxt_meas;
  logic [33:0] quot;

  always_comb begin
    quot       = ({14'h0000, hi_ff} << PCD_FS_SHIFT) / {14'h0000, per_ff};
    nxt_hi     = hi_ff + {19'h00000, sig_lvl};
    nxt_per    = per_ff + 20'h00001;
    nxt_duty   = duty_ff;
    nxt_period = period_ff;
    nxt_seen   = seen_ff;
    nxt_meas   = 1'b0;
    if (sig_rise) begin
      if (seen_ff && per_ff != 20'h00000) begin
        nxt_duty   = quot[15:0];
        nxt_period = per_ff;
        nxt_meas   = 1'b1;
      end
      nxt_hi   = 20'h00001;
      nxt_per  = 20'h00001;
      nxt_seen = 1'b1;
    end else if (per_ff >= STUCK_CYC) begin
      nxt_duty   = sig_lvl ? PCD_FS : 16'h0000;
      nxt_period = 20'h00000;
      nxt_meas   = 1'b1;
      nxt_hi     = 20'h00000;
      nxt_per    = 20'h00000;
      nxt_seen   = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_ff     <= 20'h00000;
      per_ff    <= 20'h00000;
      duty_ff   <= 16'h0000;
      period_ff <= 20'h00000;
      seen_ff   <= 1'b0;
      meas_ff   <= 1'b0;
    end else begin
      hi_ff     <= nxt_hi;
      per_ff    <= nxt_per;
      duty_ff   <= nxt_duty;
      period_ff <= nxt_period;
      seen_ff   <= nxt_seen;
      meas_ff   <= nxt_meas;
    end
  end

endmodule // pcd_duty

// >>> pcd_top.sv
// Pulse command decoder top: APB registers, position counting, ratio, duty command
// Assumes an APB master on pclk and asynchronous command pins in_a and in_b
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ps
module pcd_top import pcd_pkg::*; #(
  parameter logic [19:0] STUCK_CYC = PCD_STUCK_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Command pins
  input  wire logic        in_a,
  input  wire logic        in_b,
  // Set-points
  output logic [31:0]      pos_cmd_ff,
  output logic [15:0]      vt_cmd_ff
);
  logic        a_lvl, a_rise, a_fall, b_lvl, b_rise, b_fall;
  logic [15:0] duty;
  logic [19:0] period;
  logic        meas;
  logic [4:0]  ctrl_ff, nxt_ctrl;
  logic [15:0] num_ff, nxt_num, den_ff, nxt_den, den_eff;
  logic [31:0] cnt_ff, nxt_cnt, nxt_pos, prdata_ff, nxt_prdata;
  logic [32:0] rem_ff, nxt_rem, rem_sum;
  logic [15:0] nxt_vt;
  logic [1:0]  delta;
  logic        wr_en, rd_setup, hit;
  pcd_mode_t   mode;

  // Input conditioning
  pcd_sync u_sync_a (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (in_a),
    .lvl_ff  (a_lvl),
    .rise_ff (a_rise),
    .fall_ff (a_fall)
  );

  pcd_sync u_sync_b (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (in_b),
    .lvl_ff  (b_lvl),
    .rise_ff (b_rise),
    .fall_ff (b_fall)
  );

  pcd_duty #(.STUCK_CYC(STUCK_CYC)) u_duty (
    .pclk      (pclk),
    .presetn   (presetn),
    .sig_lvl   (a_lvl),
    .sig_rise  (a_rise),
    .duty_ff   (duty),
    .period_ff (period),
    .meas_ff   (meas)
  );

  // Mode decode
  always_comb begin
    mode = PCD_M_OFF;
    if (ctrl_ff[PCD_CTRL_EN]) begin
      if (ctrl_ff[PCD_CTRL_VT]) begin
        mode = ctrl_ff[PCD_CTRL_CTR] ? PCD_M_CENTRE : PCD_M_PWMDIR;
      end else if (ctrl_ff[PCD_CTRL_FMT +: 2] == 2'd0) begin
        mode = PCD_M_STEP;
      end else if (ctrl_ff[PCD_CTRL_FMT +: 2] == 2'd1) begin
        mode = PCD_M_UPDN;
      end else if (ctrl_ff[PCD_CTRL_FMT +: 2] == 2'd2) begin
        mode = PCD_M_QUAD;
      end
    end
  end

  // Pulse to increment: 01 forward, 11 backward, 00 none
  always_comb begin
    delta = 2'b00;
    unique case (mode)
      PCD_M_STEP: begin
        if (a_rise) begin
          delta = b_lvl ? 2'b11 : 2'b01;
        end
      end
      PCD_M_UPDN: begin
        if (a_rise && !b_rise) begin
          delta = 2'b01;
        end else if (b_rise && !a_rise) begin
          delta = 2'b11;
        end
      end
      PCD_M_QUAD: begin
        if ((a_rise | a_fall) && !(b_rise | b_fall)) begin
          delta = (a_lvl != b_lvl) ? 2'b01 : 2'b11;
        end else if ((b_rise | b_fall) && !(a_rise | a_fall)) begin
          delta = (a_lvl == b_lvl) ? 2'b01 : 2'b11;
        end
      end
      PCD_M_OFF, PCD_M_PWMDIR, PCD_M_CENTRE: begin
        delta = 2'b00;
      end
    endcase
  end

  // APB decode
  always_comb begin
    wr_en    = psel & penable & pwrite;
    rd_setup = psel & ~penable;
    hit      = (paddr == PCD_OFS_CTRL) || (paddr == PCD_OFS_NUM) ||
               (paddr == PCD_OFS_DEN) || (paddr == PCD_OFS_POS) ||
               (paddr == PCD_OFS_CNT) || (paddr == PCD_OFS_DUTY) ||
               (paddr == PCD_OFS_PERIOD);
    pready   = psel & penable;
    pslverr  = psel & penable & ~hit;
    prdata   = prdata_ff;
  end

  always_comb begin
    nxt_prdata = prdata_ff;
    if (rd_setup) begin
      unique case (paddr)
        PCD_OFS_CTRL:   nxt_prdata = {27'h0000000, ctrl_ff};
        PCD_OFS_NUM:    nxt_prdata = {16'h0000, num_ff};
        PCD_OFS_DEN:    nxt_prdata = {16'h0000, den_ff};
        PCD_OFS_POS:    nxt_prdata = pos_cmd_ff;
        PCD_OFS_CNT:    nxt_prdata = cnt_ff;
        PCD_OFS_DUTY:   nxt_prdata = {{16{vt_cmd_ff[15]}}, vt_cmd_ff};
        PCD_OFS_PERIOD: nxt_prdata = {12'h000, period};
        default:        nxt_prdata = 32'h00000000;
      endcase
    end
  end

  // Control registers
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_num  = num_ff;
    nxt_den  = den_ff;
    if (wr_en && paddr == PCD_OFS_CTRL) begin
      nxt_ctrl = pwdata[PCD_CTRL_W-1:0];
    end
    if (wr_en && paddr == PCD_OFS_NUM) begin
      nxt_num = pwdata[15:0];
    end
    if (wr_en && paddr == PCD_OFS_DEN) begin
      nxt_den = pwdata[15:0];
    end
  end

  // Pulse count and ratio scaling: one output increment per clock at most
  always_comb begin
    den_eff = (den_ff == 16'h0000) ? 16'h0001 : den_ff;
    nxt_cnt = cnt_ff;
    rem_sum = rem_ff;
    if (delta == 2'b01) begin
      nxt_cnt = cnt_ff + 32'h00000001;
      rem_sum = rem_ff + {17'h00000, num_ff};
    end else if (delta == 2'b11) begin
      nxt_cnt = cnt_ff - 32'h00000001;
      rem_sum = rem_ff - {17'h00000, num_ff};
    end
    nxt_pos = pos_cmd_ff;
    nxt_rem = rem_sum;
    if (!rem_sum[32] && rem_sum >= {17'h00000, den_eff}) begin
      nxt_rem = rem_sum - {17'h00000, den_eff};
      nxt_pos = pos_cmd_ff + 32'h00000001;
    end else if (rem_sum[32] && (-rem_sum) >= {17'h00000, den_eff}) begin
      nxt_rem = rem_sum + {17'h00000, den_eff};
      nxt_pos = pos_cmd_ff - 32'h00000001;
    end
    if (wr_en && paddr == PCD_OFS_CNT) begin
      nxt_cnt = 32'h00000000;
    end
    if (wr_en && paddr == PCD_OFS_POS) begin
      nxt_pos = pwdata;
      nxt_rem = 33'h000000000;
    end
  end

  // Velocity or torque command
  always_comb begin
    nxt_vt = vt_cmd_ff;
    unique case (mode)
      PCD_M_PWMDIR: nxt_vt = b_lvl ? (16'h0000 - duty) : duty;
      PCD_M_CENTRE: nxt_vt = {duty[14:0], 1'b0} - PCD_FS;
      PCD_M_OFF, PCD_M_STEP, PCD_M_UPDN, PCD_M_QUAD: nxt_vt = 16'h0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff    <= PCD_CTRL_RST;
      num_ff     <= PCD_NUM_RST;
      den_ff     <= PCD_DEN_RST;
      cnt_ff     <= 32'h00000000;
      rem_ff     <= 33'h000000000;
      pos_cmd_ff <= 32'h00000000;
      vt_cmd_ff  <= 16'h0000;
      prdata_ff  <= 32'h00000000;
    end else begin
      ctrl_ff    <= nxt_ctrl;
      num_ff     <= nxt_num;
      den_ff     <= nxt_den;
      cnt_ff     <= nxt_cnt;
      rem_ff     <= nxt_rem;
      pos_cmd_ff <= nxt_pos;
      vt_cmd_ff  <= nxt_vt;
      prdata_ff  <= nxt_prdata;
    end
  end

  // Checks
  logic cnt_wr;
  assign cnt_wr = wr_en && paddr == PCD_OFS_CNT;

  step_fwd_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode == PCD_M_STEP && a_rise && !b_lvl && !cnt_wr |=> cnt_ff == $past(cnt_ff) + 32'h1)
    else $error("step forward not counted");

  step_rev_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode == PCD_M_STEP && a_rise && b_lvl && !cnt_wr |=> cnt_ff == $past(cnt_ff) - 32'h1)
    else $error("step backward not counted");

  updown_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode == PCD_M_UPDN && b_rise && !a_rise && !cnt_wr |=> cnt_ff == $past(cnt_ff) - 32'h1)
    else $error("down pulse not counted");

  quad_fwd_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode == PCD_M_QUAD && a_rise && !b_lvl && !(b_rise | b_fall) && !cnt_wr
    |=> cnt_ff == $past(cnt_ff) + 32'h1)
    else $error("quadrature forward edge missed");

  ratio_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    delta == 2'b00 && !wr_en && rem_ff[32] == 1'b0 && rem_ff < {17'h0, den_eff}
    |=> pos_cmd_ff == $past(pos_cmd_ff))
    else $error("position moved without input");

  ratio_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    pos_cmd_ff == $past(pos_cmd_ff) + 32'h1 && !$past(wr_en)
    |-> rem_ff == $past(rem_sum) - {17'h0, $past(den_eff)})
    else $error("position step without ratio overflow");

  centre_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode == PCD_M_CENTRE && duty == PCD_HALF ##1 mode == PCD_M_CENTRE |-> vt_cmd_ff == 16'h0)
    else $error("half duty not zero");

  centre_ends_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode == PCD_M_CENTRE && duty == 16'h0 |=> vt_cmd_ff == 16'h0000 - PCD_FS)
    else $error("zero duty not negative full scale");

  pwm_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode == PCD_M_PWMDIR && b_lvl && duty != 16'h0 |=> vt_cmd_ff[15])
    else $error("direction high not negative");

  apb_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !hit |=> pslverr || !penable)
    else $error("unmapped address not flagged");

  up_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode == PCD_M_UPDN && a_rise && !b_rise && !cnt_wr |=> cnt_ff == $past(cnt_ff) + 32'h1)
    else $error("up pulse not counted");

  quad_rev_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode == PCD_M_QUAD && b_rise && !a_lvl && !(a_rise | a_fall) && !cnt_wr
    |=> cnt_ff == $past(cnt_ff) - 32'h1)
    else $error("quadrature reverse edge missed");

  off_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode == PCD_M_OFF && !cnt_wr |=> cnt_ff == $past(cnt_ff))
    else $error("pulse counted with decoder off");

  cnt_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_wr |=> cnt_ff == 32'h00000000)
    else $error("count write did not clear");

  ratio_rev_a: assert property (@(posedge pclk) disable iff (!presetn)
    pos_cmd_ff == $past(pos_cmd_ff) - 32'h1 && !$past(wr_en)
    |-> rem_ff == $past(rem_sum) + {17'h0, $past(den_eff)})
    else $error("position step back without ratio underflow");

  pwm_mag_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode == PCD_M_PWMDIR && !b_lvl |=> vt_cmd_ff == $past(duty))
    else $error("duty magnitude not passed through");

  centre_full_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode == PCD_M_CENTRE && duty == PCD_FS |=> vt_cmd_ff == PCD_FS)
    else $error("always-high input not positive full scale");

  vt_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode != PCD_M_PWMDIR && mode != PCD_M_CENTRE |=> vt_cmd_ff == 16'h0000)
    else $error("command set outside velocity or torque modes");

  step_seen_c:  cover property (@(posedge pclk) disable iff (!presetn)
    mode == PCD_M_STEP && a_rise ##1 pos_cmd_ff != $past(pos_cmd_ff));
  quad_rev_c:   cover property (@(posedge pclk) disable iff (!presetn)
    mode == PCD_M_QUAD && delta == 2'b11);
  duty_meas_c:  cover property (@(posedge pclk) disable iff (!presetn)
    mode == PCD_M_CENTRE && meas);
  updown_rev_c: cover property (@(posedge pclk) disable iff (!presetn)
    mode == PCD_M_UPDN && delta == 2'b11);
  centre_full_c: cover property (@(posedge pclk) disable iff (!presetn)
    mode == PCD_M_CENTRE && vt_cmd_ff == PCD_FS);

endmodule // pcd_top

// >>> pcd_ctl_model.sv
// Motion controller model: drives step, up/down, quadrature and duty pins
// Assumes pclk from the bench; pins change just after rising edges
`timescale 1ns/1ps
module pcd_ctl_model (
  // Clock
  input  wire logic pclk,
  // Command pins
  output logic      a,
  output logic      b
);
  initial begin
    a = 1'b0;
    b = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Set both levels, then wait
  task automatic set(input logic va, input logic vb, input int n);
    a <= va;
    b <= vb;
    hold(n);
  endtask

  // Pulses on a (sel 0) or b (sel 1), 4 cycles high, 4 low
  task automatic pulse(input logic sel, input int n);
    repeat (n) begin
      a <= a | !sel;
      b <= b | sel;
      hold(4);
      a <= a & sel;
      b <= b & !sel;
      hold(4);
    end
    hold(8);
  endtask

  // Encoder-style pair, one edge every 4 cycles; fwd means a leads
  task automatic quad(input logic fwd, input int n);
    logic x;
    logic y;
    for (int i = 0; i < 4 * n; i++) begin
      x = (i % 4) < 2;
      y = (i % 4 == 1) || (i % 4 == 2);
      a <= fwd ? x : y;
      b <= fwd ? y : x;
      hold(4);
    end
    hold(8);
  endtask

  // Duty train on a: hi cycles high out of per, n periods
  task automatic pwm(input int hi, input int per, input int n);
    repeat (n) begin
      a <= 1'b1;
      hold(hi);
      a <= 1'b0;
      hold(per - hi);
    end
    hold(8);
  endtask
endmodule // pcd_ctl_model

// >>> tb_top.sv
// Testbench for the pulse command decoder: APB reads checked from a queue
// Assumes pcd_top, pcd_pkg and the controller model pcd_ctl_model
`timescale 1ns/1ps
module tb_top import pcd_pkg::*;;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        in_a;
  logic        in_b;
  logic [31:0] pos_cmd_ff;
  logic [15:0] vt_cmd_ff;
  int          mismatches;
  int          n_compared;
  logic [32:0] exp_q[$];
  integer      seed;
  int          h;

  pcd_top #(.STUCK_CYC(20'd200)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .in_a(in_a), .in_b(in_b),
    .pos_cmd_ff(pos_cmd_ff), .vt_cmd_ff(vt_cmd_ff)
  );

  pcd_ctl_model ctl (.pclk(pclk), .a(in_a), .b(in_b));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic report_and_stop();
    $display("mismatches=%0d n_compared=%0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
    exp_q.push_back({err, e});
    apb(a, 1'b0, 32'h0);
  endtask

  // Compares every completed read against the oldest note
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      n_compared++;
      if (exp_q.size() == 0 || {pslverr, prdata} !== exp_q[0]) begin
        mismatches++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, {pslverr, prdata}, exp_q[0]);
      end
      if (exp_q.size() > 0 && paddr == PCD_OFS_POS &&
          pos_cmd_ff !== exp_q[0][31:0]) begin
        mismatches++;
        $display("[FAIL] t=%0t pos=%h exp=%h", $time, pos_cmd_ff, exp_q[0][31:0]);
      end
      if (exp_q.size() > 0 && paddr == PCD_OFS_DUTY &&
          vt_cmd_ff !== exp_q[0][15:0]) begin
        mismatches++;
        $display("[FAIL] t=%0t vt=%h exp=%h", $time, vt_cmd_ff, exp_q[0][15:0]);
      end
      if (exp_q.size() > 0) void'(exp_q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    report_and_stop();
  end

  initial begin
    seed = 32'h2899;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(PCD_OFS_CTRL, 32'h0, 1'b0);
    rd(PCD_OFS_NUM, 32'h1, 1'b0);
    rd(PCD_OFS_DEN, 32'h1, 1'b0);
    rd(PCD_OFS_POS, 32'h0, 1'b0);
    rd(8'h1C, 32'h0, 1'b1);
    ctl.pulse(1'b0, 2);
    rd(PCD_OFS_CNT, 32'h0, 1'b0);
    wr(PCD_OFS_CTRL, 32'h10);
    ctl.pulse(1'b0, 3);
    rd(PCD_OFS_CNT, 32'h3, 1'b0);
    rd(PCD_OFS_POS, 32'h3, 1'b0);
    ctl.set(1'b0, 1'b1, 8);
    ctl.pulse(1'b0, 2);
    rd(PCD_OFS_POS, 32'h1, 1'b0);
    wr(PCD_OFS_NUM, 32'h3);
    wr(PCD_OFS_DEN, 32'h2);
    wr(PCD_OFS_POS, 32'h0);
    wr(PCD_OFS_CNT, 32'h0);
    ctl.set(1'b0, 1'b0, 8);
    ctl.pulse(1'b0, 4);
    rd(PCD_OFS_CNT, 32'h4, 1'b0);
    rd(PCD_OFS_POS, 32'h6, 1'b0);
    wr(PCD_OFS_NUM, 32'h1);
    wr(PCD_OFS_DEN, 32'h1);
    wr(PCD_OFS_CTRL, 32'h11);
    wr(PCD_OFS_POS, 32'h0);
    ctl.pulse(1'b0, 3);
    ctl.pulse(1'b1, 1);
    rd(PCD_OFS_POS, 32'h2, 1'b0);
    wr(PCD_OFS_CTRL, 32'h12);
    wr(PCD_OFS_POS, 32'h0);
    ctl.quad(1'b1, 2);
    rd(PCD_OFS_POS, 32'h8, 1'b0);
    ctl.quad(1'b0, 1);
    rd(PCD_OFS_POS, 32'h4, 1'b0);
    wr(PCD_OFS_CTRL, 32'h13);
    ctl.quad(1'b1, 1);
    rd(PCD_OFS_POS, 32'h4, 1'b0);
    wr(PCD_OFS_CTRL, 32'h14);
    ctl.set(1'b0, 1'b0, 8);
    ctl.pwm(4, 16, 4);
    rd(PCD_OFS_DUTY, 32'h1000, 1'b0);
    rd(PCD_OFS_PERIOD, 32'h10, 1'b0);
    ctl.set(1'b0, 1'b1, 8);
    ctl.pwm(8, 16, 4);
    rd(PCD_OFS_DUTY, 32'hFFFFE000, 1'b0);
    wr(PCD_OFS_CTRL, 32'h1C);
    ctl.pwm(8, 16, 4);
    rd(PCD_OFS_DUTY, 32'h0, 1'b0);
    repeat (3) begin
      h = 3 + {$random(seed)} % 11;
      ctl.pwm(h, 16, 4);
      rd(PCD_OFS_DUTY, 32'(h * 2048 - 16384), 1'b0);
    end
    ctl.set(1'b1, 1'b0, 300);
    rd(PCD_OFS_DUTY, 32'h4000, 1'b0);
    ctl.set(1'b0, 1'b0, 300);
    rd(PCD_OFS_DUTY, 32'hFFFFC000, 1'b0);
    repeat (4) @(posedge pclk);
    report_and_stop();
  end
endmodule // tb_top
